// ===== hw/csv_estimator.sv
// Notes on behaviour
// - Accumulate only from 100 Mb receive samples.
// - Ready flag on load, cleared after read pair.
// - Control bits 14..4 read zero, ignore writes.
// - Hold bit blocks new sums reaching data.
// - Hold bit self-clears after read pair.
// - Window select picks 2, 4, 6, 8 ms.
// - New window select restarts the computation.
// - Data register loads only at window expiry.
// - Window unit is 1.048576 ms, not 1 ms.
// - Compute only while enable bit set; resets off.
// - First read low half, second high half.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
module csv_estimator #(
  parameter int unsigned UNIT_CYCLES = csv_pkg::UNIT_CYCLES,
  parameter int SMP_W = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic rx_100m_i,
  input wire logic smp_valid_i,
  input wire logic [SMP_W-1:0] smp_err_i,
  output logic irq_o
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic [5:0] idx; // Word index of the access
  logic req; // Any request pending
  logic take; // Request completes at this edge
  logic wr_ctl; // Control write completes
  logic rd_sum; // Sum read completes
  logic wr_clr; // Interrupt clear write completes
  logic wr_en; // Interrupt enable write completes

  assign idx = avs_address_i[7:2];
  assign req = avs_read_i | avs_write_i;
  // Requests complete when waitrequest is already low
  assign take = req & ~avs_waitrequest_o;
  assign wr_ctl = take & avs_write_i & avs_byteenable_i[0]
                  & (idx == csv_pkg::IDX_CONTROL);
  assign rd_sum = take & avs_read_i & (idx == csv_pkg::IDX_SUM);
  assign wr_clr = take & avs_write_i & avs_byteenable_i[0]
                  & (idx == csv_pkg::IDX_IRQ_CLEAR);
  assign wr_en = take & avs_write_i & avs_byteenable_i[0]
                 & (idx == csv_pkg::IDX_IRQ_ENABLE);

  // ****************************************************************
  // Control register
  // ****************************************************************
  logic comp_on; // Computation enabled
  logic [1:0] win_sel; // Window length select
  logic hold; // Snapshot held
  logic ready; // New sum available
  logic half_hi; // Next sum read returns the high half
  logic [1:0] next_win_sel; // Written window select
  logic next_hold; // Written hold bit
  logic win_restart; // Window select changed
  logic hold_rise; // Hold newly set by software
  logic pair_done; // Second read of the pair completes
  logic load; // Window expired and sum is taken

  assign next_win_sel = avs_writedata_i[csv_pkg::CTL_WIN_HI:
                                        csv_pkg::CTL_WIN_LO];
  assign next_hold = avs_writedata_i[csv_pkg::CTL_HOLD];
  // Only a changed value restarts; rewriting the same select
  // while touching the hold bit must not lose a window
  assign win_restart = wr_ctl & (next_win_sel != win_sel);
  assign hold_rise = wr_ctl & next_hold & ~hold;
  assign pair_done = rd_sum & half_hi;

  // Enable and window select, software owned
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      comp_on <= 1'b0;
      win_sel <= csv_pkg::WIN_RESET;
    end else if (wr_ctl) begin
      comp_on <= avs_writedata_i[csv_pkg::CTL_ON];
      win_sel <= next_win_sel;
    end
  end

  // Hold bit: software sets it, the read pair clears it
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      hold <= 1'b0;
    end else if (wr_ctl) begin
      // A software write in the same cycle wins over the pair
      hold <= next_hold;
    end else if (pair_done) begin
      hold <= 1'b0;
    end
  end

  // Ready flag: a load in the clearing cycle keeps it set
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ready <= 1'b0;
    end else if (load) begin
      ready <= 1'b1;
    end else if (pair_done) begin
      ready <= 1'b0;
    end
  end

  // Half pointer, back to the low half after a pair or new hold
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      half_hi <= 1'b0;
    end else if (hold_rise) begin
      half_hi <= 1'b0;
    end else if (rd_sum) begin
      half_hi <= ~half_hi;
    end
  end

  // ****************************************************************
  // Window timing
  // ****************************************************************
  logic [31:0] unit_cnt; // System cycles within one unit
  logic [3:0] unit_num; // Units elapsed in the window
  logic unit_end; // Last cycle of a unit
  logic win_end; // Last cycle of the window
  logic [3:0] win_units; // Units in the selected window
  logic run; // Counting and accumulating

  assign run = comp_on & ~win_restart;
  // One unit is 2**17 reference periods in system cycles
  assign unit_end = (unit_cnt == 32'(UNIT_CYCLES - 1));
  // Select 0..3 gives 2, 4, 6 or 8 units
  assign win_units = 4'(({2'h0, win_sel} + 4'h1)
                        * csv_pkg::UNITS_PER_STEP);
  assign win_end = unit_end & (unit_num == 4'(win_units - 4'h1));

  // Cycle counter inside a unit
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      unit_cnt <= 32'h0000_0000;
    end else if (~run | unit_end) begin
      unit_cnt <= 32'h0000_0000;
    end else begin
      unit_cnt <= unit_cnt + 32'h0000_0001;
    end
  end

  // Unit counter inside the window
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      unit_num <= 4'h0;
    end else if (~run | win_end) begin
      unit_num <= 4'h0;
    end else if (unit_end) begin
      unit_num <= unit_num + 4'h1;
    end
  end

  // ****************************************************************
  // Accumulation and data register
  // ****************************************************************
  logic [31:0] acc; // Running variance sum
  logic [31:0] sum_q; // Sum seen by software
  logic [31:0] sq; // Square of the incoming error
  logic smp_take; // Sample counted this cycle
  logic [31:0] acc_in; // Accumulator plus this sample

  assign sq = 32'(smp_err_i) * 32'(smp_err_i);
  assign smp_take = run & smp_valid_i & rx_100m_i;
  assign acc_in = smp_take ? acc + sq : acc;
  // The sum wraps at 32 bits; large errors over a long window
  // can overflow, which software must allow for
  assign load = run & win_end & ~hold;

  // Accumulator, emptied at each window start
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      acc <= 32'h0000_0000;
    end else if (~run | win_end) begin
      acc <= 32'h0000_0000;
    end else begin
      acc <= acc_in;
    end
  end

  // Data register, loaded only at expiry and never while held
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sum_q <= 32'h0000_0000;
    end else if (load) begin
      sum_q <= acc_in;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  logic [csv_pkg::EV_W-1:0] ev; // Events of this cycle
  logic [csv_pkg::EV_W-1:0] irq_stat; // Sticky status
  logic [csv_pkg::EV_W-1:0] irq_en; // Enable mask

  assign ev[csv_pkg::EV_LOADED] = load;
  assign ev[csv_pkg::EV_DROPPED] = run & win_end & hold;

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat <= '0;
    end else if (wr_clr) begin
      irq_stat <= (irq_stat & ~avs_writedata_i[csv_pkg::EV_W-1:0]) | ev;
    end else begin
      irq_stat <= irq_stat | ev;
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_en <= csv_pkg::IRQ_EN_RESET;
    end else if (wr_en) begin
      irq_en <= avs_writedata_i[csv_pkg::EV_W-1:0];
    end
  end

  // Registered level output, one cycle behind the status
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_en);
    end
  end

  // ****************************************************************
  // Avalon slave answer
  // ****************************************************************
  logic [31:0] rd_mux; // Read data for the pending access

  // Read multiplexer; unmapped and write-only words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (idx)
      csv_pkg::IDX_CONTROL: begin
        // Bits 14..4 stay zero whatever was written
        rd_mux[csv_pkg::CTL_READY] = ready;
        rd_mux[csv_pkg::CTL_HOLD] = hold;
        rd_mux[csv_pkg::CTL_WIN_HI:csv_pkg::CTL_WIN_LO] = win_sel;
        rd_mux[csv_pkg::CTL_ON] = comp_on;
      end
      csv_pkg::IDX_SUM: begin
        rd_mux[15:0] = half_hi ? sum_q[31:16] : sum_q[15:0];
      end
      csv_pkg::IDX_IRQ_STATUS: begin
        rd_mux[csv_pkg::EV_W-1:0] = irq_stat;
      end
      csv_pkg::IDX_IRQ_ENABLE: begin
        rd_mux[csv_pkg::EV_W-1:0] = irq_en;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // One wait cycle per access: data is latched while waiting
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else if (req & avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
      avs_readdata_o <= avs_read_i ? rd_mux : 32'h0000_0000;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_ready_on_load: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) load |=> ready)
    else $error("ready flag not set after load");

  a_ready_pair_clr: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) (pair_done && !load) |=> !ready)
    else $error("ready flag not cleared after read pair");

  a_reserved_zero: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (take && avs_read_i && idx == csv_pkg::IDX_CONTROL)
    |-> avs_readdata_o[14:4] == 11'h000)
    else $error("reserved control bits not zero");

  a_hold_blocks: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) hold |=> $stable(sum_q))
    else $error("sum changed while held");

  a_hold_selfclr: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) (pair_done && !wr_ctl) |=> !hold)
    else $error("hold bit not cleared after read pair");

  a_window_len: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    win_end |-> unit_num == 4'(2 * win_sel + 1))
    else $error("window length wrong for select");

  a_restart_clr: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    win_restart |=> (acc == 32'h0 && unit_cnt == 32'h0 && unit_num == 4'h0))
    else $error("window not restarted on new select");

  a_load_expiry: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) $changed(sum_q) |-> $past(win_end))
    else $error("sum loaded outside window expiry");

  a_off_idle: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) !comp_on |=> (acc == 32'h0 && !load))
    else $error("computation ran while disabled");

  a_only_100m: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (run && !win_end && !rx_100m_i) |=> $stable(acc))
    else $error("accumulated outside 100 Mb mode");

  a_half_order: assert property (@(posedge clk_sys_i)
    disable iff (rst_i) hold_rise |=> !half_hi)
    else $error("read pair does not start low");

  a_bus_answer: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (req && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("bus answer not given after one wait");

endmodule : csv_estimator

// ===== inc/csv_pkg.sv
// ****************************************************************
// Constants for the cable signal-quality variance estimator
// ****************************************************************
package csv_pkg;
  // Register indexes; the byte address is four times the index
  localparam logic [5:0] IDX_CONTROL = 6'h1A; // Control and ready flag
  localparam logic [5:0] IDX_SUM = 6'h1B; // Sum, two 16-bit halves
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h1C; // Sticky events, RO
  localparam logic [5:0] IDX_IRQ_CLEAR = 6'h1D; // Write one to clear
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h1E; // Interrupt mask
  // Control field positions
  localparam int CTL_ON = 0; // Computation on
  localparam int CTL_WIN_LO = 1; // Window select, low bit
  localparam int CTL_WIN_HI = 2; // Window select, high bit
  localparam int CTL_HOLD = 3; // Hold snapshot
  localparam int CTL_READY = 15; // Variance ready flag
  // Interrupt event positions
  localparam int EV_LOADED = 0; // New sum loaded
  localparam int EV_DROPPED = 1; // Sum lost while held
  localparam int EV_W = 2; // Number of events
  // Reset values
  localparam logic [1:0] WIN_RESET = 2'h0; // 2 ms window
  localparam logic [EV_W-1:0] IRQ_EN_RESET = 2'h0; // All masked
  // Timing: one window unit is 2**17 periods of an 8 ns clock
  localparam int unsigned CLK_NS = 10; // System clock period
  localparam int unsigned UNIT_REF_NS = 8; // Reference clock period
  localparam int unsigned UNIT_REF_CYCLES = 131072; // Two to the 17th
  localparam int unsigned UNIT_NS = UNIT_REF_CYCLES * UNIT_REF_NS;
  // Period, so round down to whole system cycles
  localparam int unsigned UNIT_CYCLES = UNIT_NS / CLK_NS;
  localparam int unsigned UNITS_PER_STEP = 2; // 2 ms per select step
endpackage : csv_pkg

// ===== tb/test_cable_snr_variance_estimator.sv
`timescale 1ns/1ps
// ********************************************
// Bench for the variance estimator
// ********************************************
module test_cable_snr_variance_estimator;
  localparam int unsigned U = 20; // Short window unit keeps runs brief
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic rx_100m_i = 1'b1;
  logic smp_valid_i = 1'b0;
  logic [15:0] smp_err_i = 16'h0;
  logic irq_o;
  int miscompares = 0; // Mismatches seen
  int checked = 0; // Comparisons made
  int cyc = 0; // Cycle count for the hang guard
  int n; // Measured wait in cycles
  logic [31:0] seed = 32'h00001E47; // Xorshift state, starts at 7751
  logic [31:0] q_e[$]; // Expected read values, oldest first
  logic [31:0] q_m[$]; // Bits that matter in each read
  logic [31:0] e_v, m_v; // Note taken off the queues

  csv_estimator #(.UNIT_CYCLES(U)) csv_estimator_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .rx_100m_i(rx_100m_i), .smp_valid_i(smp_valid_i),
    .smp_err_i(smp_err_i), .irq_o(irq_o));

  // 100 MHz clock
  always #5 clk_sys_i = ~clk_sys_i;

  // ********************************************
  // Helpers
  // ********************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  task automatic cmp_rd(input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] register read expected %h seen %h", e, s);
    end
  endtask : cmp_rd

  // Four-state arguments, so an unknown output cannot slip through
  task automatic cmp_val(input string what, input logic [31:0] e,
                         input logic [31:0] s);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %0d seen %0d", what, e, s);
    end
  endtask : cmp_val

  // Hang guard: well above the little over a thousand cycles the tests need
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc > 20000) begin
      miscompares++;
      summarize();
    end
  end

  // Watcher: read data stand in the cycle waitrequest is low
  always @(posedge clk_sys_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0 && q_e.size() > 0) begin
      e_v = q_e.pop_front();
      m_v = q_m.pop_front();
      cmp_rd(e_v, avs_readdata_o & m_v);
    end
  end

  // One bus access; held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [5:0] idx,
                     input logic [31:0] d, input logic [3:0] be);
    int k;
    @(posedge clk_sys_i);
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    k = 0;
    // Waitrequest is looked at on rising edges only; a wait that
    // never ends is left to the hang guard
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0);
    // One wait cycle, then the answering edge
    cmp_val("bus edges", 2, k);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  task automatic rd(input logic [5:0] idx, input logic [31:0] e,
                    input logic [31:0] m);
    q_e.push_back(e & m);
    q_m.push_back(m);
    bus(1'b0, idx, 32'h0, 4'hF);
  endtask : rd

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, 4'hF);
  endtask : wr

  // Stop, clear events, then start with a new control word
  task automatic start(input logic [31:0] c);
    wr(csv_pkg::IDX_CONTROL, 32'h0);
    wr(csv_pkg::IDX_IRQ_CLEAR, 32'h3);
    wr(csv_pkg::IDX_CONTROL, c);
  endtask : start

  // Edges until the interrupt is seen, bounded; a window of W units
  // spans W*U edges after the starting write, irq_o adds one more
  task automatic wait_irq(input int exp_n);
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1 n++;
    end while (irq_o !== 1'b1 && n < 400);
    cmp_val("window cycles", exp_n, n);
  endtask : wait_irq

  // Three known samples, then a held read pair of the loaded sum
  task automatic sum_run(input logic rx, input logic [15:0] r);
    logic [31:0] ex;
    ex = rx ? 32'(3 * r * r) : 32'h0; // Sum of squares wraps at 32 bits
    rx_100m_i <= rx;
    start(32'h1);
    repeat (3) @(posedge clk_sys_i) begin
      smp_valid_i <= 1'b1;
      smp_err_i <= r;
    end
    @(posedge clk_sys_i) smp_valid_i <= 1'b0;
    // Four edges of the window already went to the samples
    wait_irq(2 * U - 3);
    rd(csv_pkg::IDX_SUM, ex, 32'hFFFF);
    rd(csv_pkg::IDX_CONTROL, 32'h8001, 32'h8009);
    wr(csv_pkg::IDX_CONTROL, 32'h9);
    // Busy samples while held; the next window end must not load
    repeat (60) @(posedge clk_sys_i) begin
      seed = xs(seed);
      smp_valid_i <= 1'b1;
      smp_err_i <= seed[15:0];
    end
    @(posedge clk_sys_i) smp_valid_i <= 1'b0;
    rd(csv_pkg::IDX_SUM, ex, 32'hFFFF);
    rd(csv_pkg::IDX_SUM, ex >> 16, 32'hFFFF);
    rd(csv_pkg::IDX_CONTROL, 32'h0, 32'h8008);
    rd(csv_pkg::IDX_IRQ_STATUS, 32'h2, 32'h2);
    rx_100m_i <= 1'b1;
  endtask : sum_run

  // ********************************************
  // Main sequence
  // ********************************************
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    // Reset values, reserved bits, unmapped place, byte enables
    rd(csv_pkg::IDX_CONTROL, 32'h0, 32'hFFFF);
    rd(csv_pkg::IDX_SUM, 32'h0, 32'hFFFF);
    rd(csv_pkg::IDX_IRQ_ENABLE, 32'h0, 32'h3);
    rd(6'h10, 32'h0, 32'hFFFFFFFF);
    wr(csv_pkg::IDX_CONTROL, 32'hFFFF);
    rd(csv_pkg::IDX_CONTROL, 32'hF, 32'hFFFF);
    bus(1'b1, csv_pkg::IDX_CONTROL, 32'h0, 4'hE);
    rd(csv_pkg::IDX_CONTROL, 32'hF, 32'hFFFF);
    $display("test reset done");
    // Window lengths for every select value
    wr(csv_pkg::IDX_IRQ_ENABLE, 32'h3);
    for (int s = 0; s < 4; s++) begin
      start(32'(s * 2 + 1));
      wait_irq(2 * (s + 1) * U + 1);
    end
    // Masking and clearing the interrupt
    wr(csv_pkg::IDX_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    cmp_val("masked irq", 0, irq_o);
    rd(csv_pkg::IDX_IRQ_STATUS, 32'h1, 32'h1);
    wr(csv_pkg::IDX_IRQ_CLEAR, 32'h3);
    rd(csv_pkg::IDX_IRQ_STATUS, 32'h0, 32'h3);
    wr(csv_pkg::IDX_IRQ_ENABLE, 32'h3);
    $display("test window done");
    // A new select mid-window restarts the count
    start(32'h3);
    repeat (60) @(posedge clk_sys_i);
    wr(csv_pkg::IDX_CONTROL, 32'h5);
    wait_irq(6 * U + 1);
    $display("test restart done");
    seed = xs(seed);
    sum_run(1'b1, seed[15:0]);
    sum_run(1'b0, seed[31:16]);
    $display("test sum done");
    // Nothing happens while computation is off
    start(32'h0);
    repeat (200) @(posedge clk_sys_i);
    cmp_val("idle irq", 0, irq_o);
    rd(csv_pkg::IDX_IRQ_STATUS, 32'h0, 32'h3);
    $display("test off done");
    summarize();
  end
endmodule : test_cable_snr_variance_estimator
